// ==== bench/ltc_host_model.sv ====
// Host software model that sends frames on the serial control port.
// Assumes mclk_i is the block clock; each serial clock phase lasts three or four mclk cycles.
`timescale 1ns/1ps
module ltc_host_model (
  // Clock.
  input  wire logic mclk_i,
  // Serial pins.
  output logic      spi_clk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i
);
  // Idle state: clock still and select high between frames.
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // One frame; read bits are taken at the rises of the data byte, where the slave holds them.
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge mclk_i) spi_cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge mclk_i) spi_mosi_o <= f[i];
      repeat (2) @(posedge mclk_i);
      @(posedge mclk_i) spi_clk_o <= 1'b1;
      if (i < 8) q[i] = spi_miso_i;
      repeat (2) @(posedge mclk_i);
      @(posedge mclk_i) spi_clk_o <= 1'b0;
    end
    @(posedge mclk_i) spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~f[0]; // A released line must not keep showing the last bit.
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// ==== bench/ltc_top_assertions.sv ====
// Checker for the loop status levels and the switched data paths of the loop block.
// Assumes it is bound to ltc_top and sees only that module's ports.
`timescale 1ns/1ps
module ltc_top_assertions #(
  parameter int unsigned DATA_W = 16
)
(
  // Clock and reset.
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  // Serial select.
  input wire logic              spi_cs_n_i,
  // Loop levels.
  input wire logic              digital_loop_interp_o,
  input wire logic              remote_loop_decim_o,
  input wire logic              digital_loop_bitstream_o,
  input wire logic              remote_loop_bitstream_o,
  input wire logic              analog_interface_loop_o,
  input wire logic              pcm_loopback_enable_o,
  // Data paths.
  input wire logic [DATA_W-1:0] interp_tx_i,
  input wire logic [DATA_W-1:0] decim_rx_i,
  input wire logic [DATA_W-1:0] interp_tx_o,
  input wire logic [DATA_W-1:0] decim_rx_o,
  input wire logic              tx_bitstream_i,
  input wire logic              rx_bitstream_i,
  input wire logic              tx_bitstream_o,
  input wire logic              rx_bitstream_o,
  input wire logic [DATA_W-1:0] pcm_tx_i,
  input wire logic [DATA_W-1:0] core_rx_i,
  input wire logic [DATA_W-1:0] pcm_rx_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] lp;
  logic [1:0] up_reg;
  assign lp = {digital_loop_interp_o, remote_loop_decim_o, digital_loop_bitstream_o,
               remote_loop_bitstream_o, analog_interface_loop_o, pcm_loopback_enable_o};
  // Counts edges after release, since the internal reset lags the pin by two flops.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  property p_dec; up_reg == 2'h3 |-> decim_rx_o == ($past(lp[5]) ? $past(interp_tx_i) : $past(decim_rx_i)); endproperty
  a_dec: assert property (p_dec) else $error("decimator word path wrong");
  property p_int;
    up_reg == 2'h3 |-> interp_tx_o == ($past(lp[4]) ? $past(decim_rx_i) : $past(interp_tx_i));
  endproperty
  a_int: assert property (p_int) else $error("interpolator word path wrong");
  property p_ex; !(lp[5] && lp[4]); endproperty
  a_ex: assert property (p_ex) else $error("both selector loops active");
  property p_pcm; up_reg == 2'h3 |-> pcm_rx_o == ($past(lp[0]) ? $past(pcm_tx_i) : $past(core_rx_i)); endproperty
  a_pcm: assert property (p_pcm) else $error("pcm word path wrong");
  property p_pth; $onehot0(lp[3:1]); endproperty
  a_pth: assert property (p_pth) else $error("two path loops active");
  property p_rbs;
    up_reg == 2'h3 |-> rx_bitstream_o == ($past(lp[3] | lp[1]) ? $past(tx_bitstream_i) : $past(rx_bitstream_i));
  endproperty
  a_rbs: assert property (p_rbs) else $error("receive stream path wrong");
  property p_tbs;
    up_reg == 2'h3 |-> tx_bitstream_o == ($past(lp[2]) ? $past(rx_bitstream_i) : $past(tx_bitstream_i));
  endproperty
  a_tbs: assert property (p_tbs) else $error("transmit stream path wrong");
  property p_rst; disable iff (1'b0) !rst_n_i |-> lp == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("loop active in reset");
  // A loop level may only move in answer to a frame, never on its own.
  property p_chg; $changed(lp) |-> !$past(spi_cs_n_i); endproperty
  a_chg: assert property (p_chg) else $error("loop level changed outside a frame");
  // Main modes reached.
  c_int: cover property (lp[5]);
  c_rem: cover property (lp[2]);
  c_pcm: cover property (lp[0]);
  c_bs: cover property (lp[3]);
endmodule

// ==== bench/ltc_top_tb.sv ====
// Self-checking bench for the loop block: register frames, then each loop mode alone.
// Assumes the host model drives the serial pins and the checker is bound below.
`timescale 1ns/1ps
module ltc_top_tb;
  import ltc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n;
  logic        sck, cs_n, mosi, miso, miso_oe_n;
  wire         miso_line;
  wire  [5:0]  lp;
  logic [15:0] itx = 16'h0000, drx = 16'h0000, ptx = 16'h0000, crx = 16'h0000, ito, dro, pro;
  logic        tx_bitstream = 1'b0, rx_bitstream = 1'b0, tbo, rbo;
  int          err_total = 0, checks = 0;
  logic [6:0]  ma [7] = '{OFS_DIAG_SELECT, OFS_DIAG_SELECT, OFS_LOOP_PATH, OFS_LOOP_PATH, OFS_LOOP_PATH,
                          OFS_PCM_LOOPBACK, OFS_LOOP_PATH};
  logic [7:0]  mv [7] = '{8'h02, 8'h03, 8'h10, 8'h20, 8'h30, 8'h01, 8'h40};
  logic [5:0]  me [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
  // Clock.
  always #20 mclk = ~mclk;
  // The data pin has a pull-up: a released pin reads high, never the last driven bit.
  assign miso_line = miso_oe_n ? 1'b1 : miso;
  ltc_top #(.DATA_W(16)) i_ltc_top (.mclk_i(mclk), .rst_n_i(rst_n), .spi_clk_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n), .digital_loop_interp_o(lp[5]),
    .remote_loop_decim_o(lp[4]), .digital_loop_bitstream_o(lp[3]), .remote_loop_bitstream_o(lp[2]),
    .analog_interface_loop_o(lp[1]), .pcm_loopback_enable_o(lp[0]), .interp_tx_i(itx), .decim_rx_i(drx),
    .interp_tx_o(ito), .decim_rx_o(dro), .tx_bitstream_i(tx_bitstream), .rx_bitstream_i(rx_bitstream), .tx_bitstream_o(tbo),
    .rx_bitstream_o(rbo), .pcm_tx_i(ptx), .core_rx_i(crx), .pcm_rx_o(pro));
  ltc_host_model i_ltc_host_model (.mclk_i(mclk), .spi_clk_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_miso_i(miso_line));
  // Comparison, register access and verdict.
  task automatic chk(input logic [55:0] exp, input logic [55:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_ltc_host_model.frame(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_ltc_host_model.frame(1'b1, a, 8'h00, q);
    chk({48'h0, e}, {48'h0, q});
  endtask
  // Each output takes its looped source only when its own loop level is expected high.
  task automatic look(input logic [5:0] e);
    @(negedge mclk);
    chk({e, e[5] ? itx : drx, e[4] ? drx : itx, e[2] ? rx_bitstream : tx_bitstream, (e[3] | e[1]) ? tx_bitstream : rx_bitstream, e[0] ? ptx : crx},
        {lp, dro, ito, tbo, rbo, pro});
    @(posedge mclk);
  endtask
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(OFS_TEST_GATE, 8'h00);
    foreach (ma[k]) rd(ma[k], 8'h00);
    look(6'h00);
    $display("Test reset values done");
    // The gate comes first; a stored selector then acts only while the gate stays set.
    wr(OFS_TEST_GATE, 8'hFF);
    wr(OFS_DIAG_SELECT, 8'h02);
    rd(OFS_TEST_GATE, 8'h80);
    look(6'h20);
    wr(OFS_TEST_GATE, 8'h00);
    look(6'h00);
    rd(OFS_DIAG_SELECT, 8'h02);
    wr(OFS_TEST_GATE, 8'h80);
    look(6'h20);
    wr(OFS_DIAG_SELECT, 8'h00);
    wr(OFS_TEST_GATE, 8'h00);
    wr(7'h7F, 8'hFF);
    rd(7'h7F, 8'h00);
    $display("Test gate done");
    // Every mode alone with fresh data, then back to normal.
    for (int m = 0; m < 7; m++) begin
      itx <= {12'hA50, m[3:0]};
      drx <= {12'h5A0, m[3:0]};
      ptx <= {12'h3C0, m[3:0]};
      crx <= {12'hC30, m[3:0]};
      tx_bitstream <= m[0];
      rx_bitstream <= ~m[0];
      if (ma[m] == OFS_DIAG_SELECT) wr(OFS_TEST_GATE, 8'h80);
      wr(ma[m], mv[m]);
      rd(ma[m], mv[m]);
      look(me[m]);
      wr(ma[m], 8'h00);
      if (ma[m] == OFS_DIAG_SELECT) wr(OFS_TEST_GATE, 8'h00);
      look(6'h00);
    end
    $display("Test loop modes done");
    results();
  end
endmodule
bind ltc_top ltc_top_assertions #(.DATA_W(DATA_W)) i_ltc_top_assertions (.*);

// ==== hw/ltc_pkg.sv ====
// Constants shared by the loopback test control block and its serial control port.
// Assumes one 25 MHz clock and a serial port whose pins are already synchronous to it.
package ltc_pkg;

  // Register offsets on the serial control port.
  localparam logic [6:0] OFS_TEST_GATE    = 7'h02;
  localparam logic [6:0] OFS_DIAG_SELECT  = 7'h07;
  localparam logic [6:0] OFS_LOOP_PATH    = 7'h18;
  localparam logic [6:0] OFS_PCM_LOOPBACK = 7'h24;

  // Field positions inside the 8-bit registers.
  localparam int unsigned POS_GATE      = 7;
  localparam int unsigned POS_DIAG_LO   = 0;
  localparam int unsigned POS_PATH_LO   = 4;
  localparam int unsigned POS_PCM_LB    = 0;

  // Values after reset: every loop off.
  localparam logic       RST_GATE       = 1'b0;
  localparam logic [1:0] RST_DIAG       = 2'h0;
  localparam logic [3:0] RST_PATH       = 4'h0;
  localparam logic       RST_PCM_LB     = 1'b0;

  // Digital diagnostic selector codes.
  localparam logic [1:0] DIAG_NORMAL    = 2'h0;
  localparam logic [1:0] DIAG_INTERP    = 2'h2;
  localparam logic [1:0] DIAG_DECIM     = 2'h3;

  // Loop path select codes.
  localparam logic [3:0] PATH_NORMAL    = 4'h0;
  localparam logic [3:0] PATH_BS_DIGITAL = 4'h1;
  localparam logic [3:0] PATH_BS_REMOTE = 4'h2;
  localparam logic [3:0] PATH_ANALOG_IF = 4'h3;

  // Serial frame: command byte (read flag, 7-bit address) then one data byte.
  localparam logic [4:0] SPI_CMD_BITS   = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

endpackage

// ==== hw/ltc_spi_slave.sv ====
// Serial control port slave: 16-bit frames, most significant bit first.
// Assumes clock, select and data pins are synchronous to mclk_i and slower than mclk_i / 4.
`timescale 1ns/1ps
module ltc_spi_slave
  import ltc_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Serial pins.
  input  wire logic       spi_clk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_n_o,
  // Register side.
  output logic [6:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  input  wire logic [7:0] reg_rdata_i
);

  typedef struct packed {
    logic       clk_prev;
    logic [4:0] count;
    logic [7:0] shift_in;
    logic       is_read;
    logic [6:0] addr;
    logic [7:0] shift_out;
    logic [7:0] wdata;
    logic       wr;
  } ltc_spi_s;

  ltc_spi_s state_reg;
  ltc_spi_s state_next;

  // Bits are taken on the rising serial edge; read data moves on the falling one.
  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    state_next = state_reg;
    state_next.clk_prev = spi_clk_i;
    state_next.wr = 1'b0;
    rise = spi_clk_i & ~state_reg.clk_prev;
    fall = ~spi_clk_i & state_reg.clk_prev;
    if (spi_cs_n_i) begin
      // A deselect abandons any partial frame, so a short frame never writes.
      state_next.count = 5'h00;
      state_next.is_read = 1'b0;
    end else if (rise && state_reg.count < SPI_FRAME_BITS) begin
      state_next.shift_in = {state_reg.shift_in[6:0], spi_mosi_i};
      state_next.count = state_reg.count + 5'h01;
      if (state_reg.count == SPI_CMD_BITS - 5'h01) begin
        state_next.is_read = state_reg.shift_in[6];
        state_next.addr = {state_reg.shift_in[5:0], spi_mosi_i};
      end
      if (state_reg.count == SPI_FRAME_BITS - 5'h01 && !state_reg.is_read) begin
        state_next.wdata = {state_reg.shift_in[6:0], spi_mosi_i};
        state_next.wr = 1'b1;
      end
    end else if (fall && state_reg.count > SPI_CMD_BITS && state_reg.count < SPI_FRAME_BITS) begin
      state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
    end else if (state_reg.count == SPI_CMD_BITS && spi_clk_i) begin
      // The address flop has settled, so the register value is loaded from a stable address.
      state_next.shift_out = reg_rdata_i;
    end
  end

  // The address comes from its flop, which keeps the read path free of a loop through this logic.
  always_comb begin
    reg_addr_o = state_reg.addr;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '{clk_prev: 1'b0, count: 5'h00, shift_in: 8'h00, is_read: 1'b0,
                     addr: 7'h00, shift_out: 8'h00, wdata: 8'h00, wr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // The data pin is driven only in the data phase of a read.
  assign spi_miso_o      = state_reg.shift_out[7];
  assign spi_miso_oe_n_o = ~(state_reg.is_read & ~spi_cs_n_i & (state_reg.count >= SPI_CMD_BITS));
  assign reg_wdata_o     = state_reg.wdata;
  assign reg_wr_o        = state_reg.wr;

endmodule

// ==== hw/ltc_top.sv ====
// Loopback test control: control registers and the data path switches they steer.
// Assumes the data path words are synchronous to mclk_i; each path adds one clock of latency.
// Assumes the registers are reached only through the serial control port, with no parallel bus.
// Loop levels are decoded from the control flops; every switched data output is registered.
`timescale 1ns/1ps
module ltc_top
  import ltc_pkg::*;
#(
  parameter int unsigned DATA_W = 16
)
(
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // Serial control port.
  input  wire logic              spi_clk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  output logic                   spi_miso_oe_n_o,
  // Loop status, one level per loop.
  output logic                   digital_loop_interp_o,
  output logic                   remote_loop_decim_o,
  output logic                   digital_loop_bitstream_o,
  output logic                   remote_loop_bitstream_o,
  output logic                   analog_interface_loop_o,
  output logic                   pcm_loopback_enable_o,
  // Interpolator and decimator words.
  input  wire logic [DATA_W-1:0] interp_tx_i,
  input  wire logic [DATA_W-1:0] decim_rx_i,
  output logic [DATA_W-1:0]      interp_tx_o,
  output logic [DATA_W-1:0]      decim_rx_o,
  // Bit streams between the host side and the line side.
  input  wire logic              tx_bitstream_i,
  input  wire logic              rx_bitstream_i,
  output logic                   tx_bitstream_o,
  output logic                   rx_bitstream_o,
  // PCM words between the compander and the core.
  input  wire logic [DATA_W-1:0] pcm_tx_i,
  input  wire logic [DATA_W-1:0] core_rx_i,
  output logic [DATA_W-1:0]      pcm_rx_o
);

  // All control and data path state in one record: the four loop controls, then the registered data path outputs.
  // Only the field bits are kept, so the control part of the record is eight flops wide.
  typedef struct packed {
    // Loop controls.
    logic              gate;
    logic [1:0]        diag;
    logic [3:0]        path;
    logic              pcm_lb;

    // Registered data path outputs.
    logic [DATA_W-1:0] interp_tx;
    logic [DATA_W-1:0] decim_rx;
    logic              tx_bs;
    logic              rx_bs;
    logic [DATA_W-1:0] pcm_rx;
  } ltc_top_s;

  // State and internal reset.
  ltc_top_s   state_reg;
  ltc_top_s   state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  // Register port of the serial slave.
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic [7:0] reg_rdata;
  // Decoded loop levels.
  logic       loop_interp;
  logic       loop_decim;
  logic       loop_bs_digital;
  logic       loop_bs_remote;
  logic       loop_analog_if;

  // Reset is taken asynchronously and released through two flip-flops.
  // Only the second flop feeds the logic, so a release close to an edge cannot split the design.
  // The pin reset still clears the slave and the controls at once, so no loop survives a reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Serial control port; its address comes from a flop and its write pulse lasts one clock.
  ltc_spi_slave i_ltc_spi_slave (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n),
    .spi_clk_i       (spi_clk_i),
    .spi_cs_n_i      (spi_cs_n_i),
    .spi_mosi_i      (spi_mosi_i),
    .spi_miso_o      (spi_miso_o),
    .spi_miso_oe_n_o (spi_miso_oe_n_o),
    .reg_addr_o      (reg_addr),
    .reg_wdata_o     (reg_wdata),
    .reg_wr_o        (reg_wr),
    .reg_rdata_i     (reg_rdata)
  );

  // Register map, one field per register:
  //   test gate      offset 0x02, bit 7     arms the selector loops;
  //   diag selector  offset 0x07, bits 1:0  picks the interpolator or the decimator loop;
  //   loop path      offset 0x18, bits 7:4  picks one of the bit stream loops;
  //   PCM loopback   offset 0x24, bit 0     turns PCM words round before the core.
  // Every field is read-write; writing any other bit of a register has no effect.
  // Read view of one address; bits outside the loop fields and unknown addresses read zero.
  function automatic logic [7:0] read_view(input logic [6:0] addr, input ltc_top_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      OFS_TEST_GATE:    v[POS_GATE] = s.gate;
      OFS_DIAG_SELECT:  v[POS_DIAG_LO +: 2] = s.diag;
      OFS_LOOP_PATH:    v[POS_PATH_LO +: 4] = s.path;
      OFS_PCM_LOOPBACK: v[POS_PCM_LB] = s.pcm_lb;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // Read data follows the address combinationally; the slave loads it once the address has settled.
  assign reg_rdata = read_view(reg_addr, state_reg);

  // Loop decode. The selector is stored even while the gate is clear, but acts only
  // with the gate set, so software that writes the selector early is harmless.
  // Path codes are compared whole, so codes 0100 to 1111 are stored and read back but select no loop.
  // The levels are combinational, so they change in the same clock as the control flop behind them.
  assign loop_interp     = state_reg.gate & (state_reg.diag == DIAG_INTERP);
  assign loop_decim      = state_reg.gate & (state_reg.diag == DIAG_DECIM);
  assign loop_bs_digital = (state_reg.path == PATH_BS_DIGITAL);
  assign loop_bs_remote  = (state_reg.path == PATH_BS_REMOTE);
  assign loop_analog_if  = (state_reg.path == PATH_ANALOG_IF);

  // Register writes and the registered data path switches.
  // Several loops may be set at once; each switch then acts on its own, and the result
  // is only as meaningful as software's choice of combination.
  // A write to an address outside the map falls into the default arm and changes nothing.
  always_comb begin
    state_next = state_reg;
    // Each write touches one field only; the other controls keep their values.
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_TEST_GATE:    state_next.gate = reg_wdata[POS_GATE];
        OFS_DIAG_SELECT:  state_next.diag = reg_wdata[POS_DIAG_LO +: 2];
        OFS_LOOP_PATH:    state_next.path = reg_wdata[POS_PATH_LO +: 4];
        OFS_PCM_LOOPBACK: state_next.pcm_lb = reg_wdata[POS_PCM_LB];
        default:          state_next.gate = state_reg.gate;
      endcase
    end

    // The switches use the controls as they stand now, so a new loop acts one clock after its write.
    // Interpolated transmit words replace the decimated receive input.
    if (loop_interp) begin
      state_next.decim_rx = interp_tx_i;
    end else begin
      state_next.decim_rx = decim_rx_i;
    end

    // Received words are sent back out toward the D/A converter.
    if (loop_decim) begin
      state_next.interp_tx = decim_rx_i;
    end else begin
      state_next.interp_tx = interp_tx_i;
    end

    // Transmit stream from the PCM input reaches the receive channel and the PCM output.
    if (loop_bs_digital | loop_analog_if) begin
      state_next.rx_bs = tx_bitstream_i;
    end else begin
      state_next.rx_bs = rx_bitstream_i;
    end

    // Receive stream is fed back into the transmit stream and the analog transmit channel.
    if (loop_bs_remote) begin
      state_next.tx_bs = rx_bitstream_i;
    end else begin
      state_next.tx_bs = tx_bitstream_i;
    end

    // PCM words turn round before the core.
    if (state_reg.pcm_lb) begin
      state_next.pcm_rx = pcm_tx_i;
    end else begin
      state_next.pcm_rx = core_rx_i;
    end
  end

  // Every loop control clears on reset, so the device powers up in normal operation.
  // The data outputs clear too, so nothing stale appears on a path in the first clock after release.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{gate:      RST_GATE,
                     diag:      RST_DIAG,
                     path:      RST_PATH,
                     pcm_lb:    RST_PCM_LB,
                     interp_tx: '0,
                     decim_rx:  '0,
                     tx_bs:     1'b0,
                     rx_bs:     1'b0,
                     pcm_rx:    '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Status levels, straight from the decode; they are not delayed like the data.
  assign digital_loop_interp_o    = loop_interp;
  assign remote_loop_decim_o      = loop_decim;
  assign digital_loop_bitstream_o = loop_bs_digital;
  assign remote_loop_bitstream_o  = loop_bs_remote;
  assign analog_interface_loop_o  = loop_analog_if;
  assign pcm_loopback_enable_o    = state_reg.pcm_lb;

  // Registered data outputs; each lags its selected input by one clock.
  assign interp_tx_o              = state_reg.interp_tx;
  assign decim_rx_o               = state_reg.decim_rx;
  assign tx_bitstream_o           = state_reg.tx_bs;
  assign rx_bitstream_o           = state_reg.rx_bs;
  assign pcm_rx_o                 = state_reg.pcm_rx;

endmodule
